// >>> rtl/smd_pkg.sv
// Constants, field layouts and types of the signed multiply/divide unit.
// Assumes an APB master on pclk; no other package is needed.
package smd_pkg;
   // ==========================================================
   // Register map (byte addresses, one aligned word each)
   localparam logic [7:0] SMD_GPR_BASE = 8'h00;
   localparam logic [7:0] SMD_GPR_STEP = 8'h04;
   localparam logic [7:0] SMD_SRC_OFS = 8'h20;
   localparam logic [7:0] SMD_INSTR_OFS = 8'h24;
   localparam logic [7:0] SMD_STATUS_OFS = 8'h28;
   localparam int SMD_NUM_GPR = 8;
   // ==========================================================
   // Instruction fields
   localparam int SMD_OP_LSB = 9;
   localparam int SMD_REG_LSB = 6;
   localparam logic [6:0] SMD_OP_PRODUCT = 7'h38;
   localparam logic [6:0] SMD_OP_DIVIDE = 7'h39;
   // ==========================================================
   // Status word fields
   localparam int SMD_ST_BUSY = 4;
   localparam int SMD_ST_ABORT = 5;
   localparam int SMD_ST_BADOP = 6;
   // ==========================================================
   // Reset values and arithmetic bounds
   localparam logic [15:0] SMD_GPR_RESET = 16'h0000;
   localparam logic [15:0] SMD_INSTR_RESET = 16'h0000;
   localparam logic [3:0] SMD_FLAGS_RESET = 4'h0;
   localparam logic signed [31:0] SMD_MUL_LO = 32'shffff_8000;
   localparam logic signed [31:0] SMD_MUL_HI = 32'sh0000_7fff;
   localparam logic signed [32:0] SMD_Q_MAX = 33'sh0_0000_7fff;
   localparam logic signed [32:0] SMD_Q_MIN = 33'sh1_ffff_8000;
   // ==========================================================
   // Types
   typedef struct packed {
      logic n;
      logic z;
      logic v;
      logic c;
   } smd_flags_t;
   typedef enum logic [1:0] {
      SMD_IDLE = 2'b01,
      SMD_EXEC = 2'b10
   } smd_state_t;
endpackage : smd_pkg

// >>> rtl/smd_unit.sv
// Signed multiply/divide datapath with its own eight-word register bank.
// Assumes an APB master on pclk; the source operand is already fetched into SRC.
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module smd_unit (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   // ==========================================================
   // State
   smd_pkg::smd_state_t state_r;
   smd_pkg::smd_flags_t flags_r;
   smd_pkg::smd_flags_t flags_nxt;
   logic [15:0] instr_r;
   logic [15:0] src_r;
   logic [15:0] gpr_r [0:smd_pkg::SMD_NUM_GPR-1];
   logic abort_r;
   logic badop_r;
   logic exec;
   logic apb_wr;
   logic start;
   // ==========================================================
   // Decode
   logic [6:0] op;
   logic [2:0] rsel;
   logic [2:0] rpair;
   logic is_mul;
   logic is_div;
   assign op = instr_r[15:smd_pkg::SMD_OP_LSB];
   assign rsel = instr_r[smd_pkg::SMD_OP_LSB-1:smd_pkg::SMD_REG_LSB];
   // Odd partner; an odd divide register pairs with itself
   assign rpair = rsel | 3'h1;
   assign is_mul = (op == smd_pkg::SMD_OP_PRODUCT);
   assign is_div = (op == smd_pkg::SMD_OP_DIVIDE);
   assign exec = (state_r == smd_pkg::SMD_EXEC);
   // ==========================================================
   // Arithmetic
   logic [15:0] r_val;
   logic [15:0] p_val;
   logic [15:0] other_val;
   logic signed [31:0] prod;
   logic [15:0] prod_hi;
   logic [15:0] prod_lo;
   logic mul_wide;
   logic signed [32:0] dvd;
   logic signed [32:0] dvs;
   logic signed [32:0] quo;
   logic signed [32:0] rem;
   logic [15:0] quo_lo;
   logic [15:0] rem_lo;
   logic div_zero;
   logic div_ovf;
   logic div_abort;
   assign r_val = gpr_r[rsel];
   assign p_val = gpr_r[rpair];
   assign other_val = gpr_r[rsel ^ 3'h1];
   assign prod = $signed(r_val) * $signed(src_r);
   assign prod_hi = prod[31:16];
   assign prod_lo = prod[15:0];
   assign mul_wide = (prod < smd_pkg::SMD_MUL_LO) || (prod >= smd_pkg::SMD_MUL_HI);
   assign dvd = {r_val[15], r_val, p_val};
   assign dvs = {{17{src_r[15]}}, src_r};
   assign div_zero = (src_r == 16'h0000);
   // Divisor forced to one on zero so the divider never sees an undefined case
   // Signed division truncates toward zero, so the remainder follows the dividend
   assign quo = dvd / (div_zero ? 33'sh0_0000_0001 : dvs);
   assign rem = dvd % (div_zero ? 33'sh0_0000_0001 : dvs);
   assign quo_lo = quo[15:0];
   assign rem_lo = rem[15:0];
   // Wide quotient range check also covers the most-negative by minus-one case
   assign div_ovf = (quo > smd_pkg::SMD_Q_MAX) || (quo < smd_pkg::SMD_Q_MIN);
   assign div_abort = div_zero || div_ovf;
   // ==========================================================
   // Flags
   always_comb begin
      flags_nxt = flags_r;
      if (is_mul) begin
         flags_nxt.n = prod[31];
         flags_nxt.z = (prod == 32'sh0000_0000);
         flags_nxt.v = 1'b0;
         flags_nxt.c = mul_wide;
      end else if (is_div) begin
         flags_nxt.n = !div_abort && quo[32];
         flags_nxt.z = !div_abort && (quo == 33'sh0_0000_0000);
         flags_nxt.v = div_abort;
         flags_nxt.c = div_zero;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_r <= smd_pkg::smd_flags_t'(smd_pkg::SMD_FLAGS_RESET);
         abort_r <= 1'b0;
         badop_r <= 1'b0;
      end else if (exec) begin
         flags_r <= flags_nxt;
         abort_r <= is_div && div_abort;
         badop_r <= !is_mul && !is_div;
      end
   end
   // ==========================================================
   // APB slave; stalls one cycle while an instruction executes
   logic [7:0] gpr_end;
   logic mapped;
   assign pready = (state_r == smd_pkg::SMD_IDLE);
   assign apb_wr = psel && penable && pwrite && pready;
   assign start = apb_wr && (paddr == smd_pkg::SMD_INSTR_OFS);
   assign gpr_end = smd_pkg::SMD_GPR_BASE + 8'(smd_pkg::SMD_NUM_GPR * 4);
   assign mapped = (paddr[1:0] == 2'b00) &&
                   ((paddr < gpr_end) || (paddr == smd_pkg::SMD_SRC_OFS) ||
                    (paddr == smd_pkg::SMD_INSTR_OFS) || (paddr == smd_pkg::SMD_STATUS_OFS));
   assign pslverr = psel && penable && pready && !mapped;
   always_comb begin
      prdata = 32'h0000_0000;
      if (paddr[1:0] == 2'b00) begin
         if (paddr < gpr_end) begin
            prdata = {16'h0000, gpr_r[paddr[4:2]]};
         end else if (paddr == smd_pkg::SMD_SRC_OFS) begin
            prdata = {16'h0000, src_r};
         end else if (paddr == smd_pkg::SMD_INSTR_OFS) begin
            prdata = {16'h0000, instr_r};
         end else if (paddr == smd_pkg::SMD_STATUS_OFS) begin
            prdata[3:0] = flags_r;
            prdata[smd_pkg::SMD_ST_BUSY] = exec;
            prdata[smd_pkg::SMD_ST_ABORT] = abort_r;
            prdata[smd_pkg::SMD_ST_BADOP] = badop_r;
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_r <= smd_pkg::SMD_GPR_RESET;
      end else if (apb_wr && (paddr == smd_pkg::SMD_SRC_OFS)) begin
         src_r <= pwdata[15:0];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         instr_r <= smd_pkg::SMD_INSTR_RESET;
      end else if (start) begin
         instr_r <= pwdata[15:0];
      end
   end
   // ==========================================================
   // Sequencer: one execute cycle per instruction write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= smd_pkg::SMD_IDLE;
      end else begin
         case (state_r)
            smd_pkg::SMD_IDLE: begin
               if (start) begin
                  state_r <= smd_pkg::SMD_EXEC;
               end
            end
            smd_pkg::SMD_EXEC: begin
               state_r <= smd_pkg::SMD_IDLE;
            end
            default: begin
               state_r <= smd_pkg::SMD_IDLE;
            end
         endcase
      end
   end
   // ==========================================================
   // Register bank
   genvar gi;
   generate
      for (gi = 0; gi < smd_pkg::SMD_NUM_GPR; gi++) begin : g_gpr
         localparam logic [2:0] IDX = 3'(gi);
         localparam logic [7:0] ADDR = smd_pkg::SMD_GPR_BASE + 8'(gi * 4);
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               gpr_r[gi] <= smd_pkg::SMD_GPR_RESET;
            end else if (exec && is_mul) begin
               if (!rsel[0] && (rsel == IDX)) begin
                  gpr_r[gi] <= prod_hi;
               end else if (!rsel[0] && (rpair == IDX)) begin
                  gpr_r[gi] <= prod_lo;
               end else if (rsel == IDX) begin
                  gpr_r[gi] <= prod_lo;
               end
            end else if (exec && is_div && !div_abort) begin
               if (rsel == IDX) begin
                  gpr_r[gi] <= quo_lo;
               end else if (rpair == IDX) begin
                  gpr_r[gi] <= rem_lo;
               end
            end else if (apb_wr && (paddr == ADDR)) begin
               gpr_r[gi] <= pwdata[15:0];
            end
         end
      end
   endgenerate
   // ==========================================================
   // Assertions
   property p_mul_even;
      @(posedge pclk) disable iff (!presetn)
      (exec && is_mul && !rsel[0]) |=>
         (gpr_r[$past(rsel)] == $past(prod_hi)) && (gpr_r[$past(rpair)] == $past(prod_lo));
   endproperty
   a_mul_even: assert property (p_mul_even) else $error("even product halves wrong");
   property p_mul_odd;
      @(posedge pclk) disable iff (!presetn)
      (exec && is_mul && rsel[0]) |=>
         (gpr_r[$past(rsel)] == $past(prod_lo)) &&
         (gpr_r[$past(rsel) ^ 3'h1] == $past(other_val));
   endproperty
   a_mul_odd: assert property (p_mul_odd) else $error("odd product write wrong");
   property p_mul_flags;
      @(posedge pclk) disable iff (!presetn)
      (exec && is_mul) |=>
         (flags_r.n == $past(prod[31])) && (flags_r.z == ($past(prod) == 0)) && !flags_r.v;
   endproperty
   a_mul_flags: assert property (p_mul_flags) else $error("product N Z V wrong");
   property p_mul_carry;
      @(posedge pclk) disable iff (!presetn)
      (exec && is_mul) |=>
         flags_r.c == (($past(prod) < -32768) || ($past(prod) >= 32767));
   endproperty
   a_mul_carry: assert property (p_mul_carry) else $error("product carry wrong");
   property p_div_write;
      @(posedge pclk) disable iff (!presetn)
      (exec && is_div && !div_abort) |=>
         (gpr_r[$past(rsel)] == $past(quo_lo)) && (gpr_r[$past(rpair)] == $past(rem_lo));
   endproperty
   a_div_write: assert property (p_div_write) else $error("divide results misplaced");
   property p_div_sign;
      @(posedge pclk) disable iff (!presetn)
      (exec && is_div && !div_abort) |->
         ((rem == 0) || (rem[32] == dvd[32])) && (quo * dvs + rem == dvd);
   endproperty
   a_div_sign: assert property (p_div_sign) else $error("remainder sign wrong");
   property p_div_flags;
      @(posedge pclk) disable iff (!presetn)
      (exec && is_div) |=>
         (flags_r.v == $past(div_abort)) && (flags_r.c == $past(div_zero)) &&
         ($past(div_abort) || (flags_r.n == $past(quo[32])));
   endproperty
   a_div_flags: assert property (p_div_flags) else $error("divide flags wrong");
   property p_div_hold;
      @(posedge pclk) disable iff (!presetn)
      (exec && is_div && div_abort) |=>
         (gpr_r[$past(rsel)] == $past(r_val)) && (gpr_r[$past(rpair)] == $past(p_val)) &&
         abort_r;
   endproperty
   a_div_hold: assert property (p_div_hold) else $error("aborted divide wrote");
   property p_start;
      @(posedge pclk) disable iff (!presetn)
      start |=> exec && !pready ##1 !exec && pready;
   endproperty
   a_start: assert property (p_start) else $error("execute cycle not single");
endmodule : smd_unit
`default_nettype wire

// >>> testbench/smd_host.sv
// APB master standing in for the processor core side of the unit.
// Assumes one clock pclk; each transfer is started just after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module smd_host (
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // ==========================================================
   // Idle bus at time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
   end
   // ==========================================================
   // One transfer, request held until pready is seen at an edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err, output logic tmo);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // Read right at the edge: slave updates land later in this time step
      while (pready !== 1'b1 && n < 40) begin
         n++;
         @(posedge pclk);
      end
      tmo = (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      // One idle cycle keeps two drives of psel out of one time step
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : xfer
endmodule : smd_host
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench of the multiply/divide unit against a behavioural model.
// Assumes smd_unit and smd_host are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [15:0] gm [8];
   logic [6:0] st;
   int n_fail, cmp_count, seed;
   smd_unit smd_unit_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   smd_host smd_host_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   always #50 pclk = ~pclk;
   // ==========================================================
   // Checking and bus helpers
   task automatic stop_test();
      $display("Counts: %0d compares, %0d mismatches", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : stop_test
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      logic tmo;
      smd_host_i.xfer(w, a, d, q, e, tmo);
      if (tmo) begin
         n_fail++;
         stop_test();
      end
   endtask : acc
   task automatic chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic e;
      acc(1'b0, a, 32'h0000_0000, q, e);
      cmp(q, exp);
   endtask : chk
   task automatic wreg(input int i, input logic [15:0] v);
      logic [31:0] x;
      logic e;
      acc(1'b1, 8'(4 * i), {16'h0000, v}, x, e);
      gm[i] = v;
   endtask : wreg
   // ==========================================================
   // Issue one instruction, update the model, compare the status word and all eight registers
   task automatic run(input logic [6:0] op, input int r, input logic [15:0] s);
      longint p, q;
      logic [31:0] x;
      logic e;
      acc(1'b1, 8'h20, {16'h0000, s}, x, e);
      acc(1'b1, 8'h24, {16'h0000, op, r[2:0], 6'h00}, x, e);
      if (op == 7'h38) begin
         p = $signed(gm[r]);
         p = p * $signed(s);
         st = {3'b000, (p < 0), (p == 0), 1'b0, (p < -32768 || p >= 32767)};
         if (r[0]) begin
            gm[r] = p[15:0];
         end else begin
            gm[r] = p[31:16];
            gm[r + 1] = p[15:0];
         end
      end else if (op == 7'h39) begin
         p = $signed({gm[r], gm[r + 1]});
         q = (s == 16'h0000) ? 0 : p / $signed(s);
         if (s == 16'h0000) begin
            st = 7'h23;
         end else if (q > 32767 || q < -32768) begin
            st = 7'h22;
         end else begin
            st = {3'b000, (q < 0), (q == 0), 2'b00};
            p = p % $signed(s);
            gm[r] = q[15:0];
            gm[r + 1] = p[15:0];
         end
      end else begin
         // Unknown opcode: flags kept, registers kept, bad-opcode bit set
         st = {1'b1, 2'b00, st[3:0]};
      end
      chk(8'h28, 32'(st));
      for (int i = 0; i < 8; i++) begin
         chk(8'(4 * i), {16'h0000, gm[i]});
      end
   endtask : run
   task automatic tc(input logic [6:0] op, input int r, input logic [15:0] a, b, s);
      wreg(r, a);
      wreg(r ^ 1, b);
      run(op, r, s);
   endtask : tc
   // ==========================================================
   // Main sequence
   initial begin
      logic [31:0] x;
      logic e;
      pclk = 1'b0;
      presetn = 1'b0;
      seed = 67741;
      n_fail = 0;
      cmp_count = 0;
      st = 7'h00;
      for (int i = 0; i < 8; i++) gm[i] = 16'h0000;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk(8'h28, 32'h0000_0000);
      acc(1'b0, 8'h2c, 32'h0000_0000, x, e);
      cmp(32'(e), 32'h0000_0001);
      acc(1'b0, 8'h02, 32'h0000_0000, x, e);
      cmp(32'(e), 32'h0000_0001);
      cmp(x, 32'h0000_0000);
      acc(1'b1, 8'h28, 32'h0000_007f, x, e);
      chk(8'h28, 32'h0000_0000);
      $display("Test reset and map done");
      // Divides name even registers only
      tc(7'h39, 0, 16'h0000, 16'h2001, 16'h0002);
      tc(7'h39, 2, 16'hffff, 16'hfff9, 16'h0002);
      tc(7'h39, 4, 16'h0000, 16'h0007, 16'hfffe);
      tc(7'h39, 6, 16'h0000, 16'h0001, 16'h0002);
      tc(7'h39, 0, 16'h1234, 16'h5678, 16'h0000);
      tc(7'h39, 4, 16'h8000, 16'h0000, 16'hffff);
      tc(7'h39, 2, 16'h0001, 16'h0000, 16'h0001);
      tc(7'h39, 6, 16'hffff, 16'h8000, 16'h0001);
      $display("Test divide done");
      tc(7'h38, 2, 16'h8000, 16'h1234, 16'hffff);
      tc(7'h38, 1, 16'h0100, 16'h5555, 16'h0008);
      tc(7'h38, 3, 16'h7fff, 16'h0000, 16'h0001);
      tc(7'h38, 5, 16'h8000, 16'h1111, 16'h0001);
      tc(7'h38, 5, 16'h8000, 16'h1111, 16'hffff);
      tc(7'h38, 4, 16'hff00, 16'h0000, 16'h0101);
      tc(7'h38, 6, 16'h1234, 16'hffff, 16'h0000);
      tc(7'h3a, 2, 16'h1234, 16'h5678, 16'h0003);
      $display("Test multiply done");
      for (int k = 0; k < 24; k++) begin
         x = $random(seed);
         if (k[0]) begin
            tc(7'h38, x[18:16], x[15:0], x[31:16], 16'($random(seed)));
         end else begin
            tc(7'h39, {x[18:17], 1'b0}, {16{x[15]}}, x[15:0], 16'($random(seed)));
         end
      end
      $display("Test random done");
      stop_test();
   end
endmodule : testbench
`default_nettype wire
